// file: shared/cfs_pkg.sv
// Constants, types and register map of the cooling fan supervisor.
// Assumes one 50 MHz clock and a power-on reset that is also the supply cycle.
// What this block does
// - Power-up needs one working fan, else no load and 2 Hz red/yellow flashing.
// - Cooling needed with no working fan: reset state after a minute, show eight.
// - Reset state stays latched until supply power is removed.
// - Pair with one fan failed is functional; both failed means defective.
// - After one fan fails, surviving fan runs at full load, event raised in run.
// - A fan is judged only while on; too slow or stopped means faulty.
// - Power-on fan test: pair switched on briefly, rotation checked.
// - Periodic brief test run in operation even without cooling demand.
// - Fans switch on from supply air temperature and processor load.
// - Failure while stopped: flag and diagnostic entry, but no event.
// - One of pair fails in run: code 205, detail 4000h, spare-lost flag.
// - Single or both fans fail in run: code 205, detail 80h, fan flag.
// - Both of pair failed: fan flag only, reset state after a minute.
// - Broken spare at power-up may show the unit as a single fan.
// - Fitted cooler kind reported as single, pair or none, kept current.
package cfs_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_NS       = 1_000_000;
  localparam int unsigned TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MINUTE_S      = 60;
  localparam int unsigned MINUTE_MS     = MINUTE_S * 1000;
  localparam int unsigned BLINK_HZ      = 2;
  localparam int unsigned BLINK_HALF_MS = 1000 / (2 * BLINK_HZ);
  localparam int unsigned TEST_MS       = 2000;
  localparam int unsigned INTERVAL_MS   = 600_000;
  localparam int unsigned WIN_MS        = 200;
  localparam int unsigned MIN_PULSES    = 10;

  // ----------------------------------------
  // Event codes
  // ----------------------------------------
  localparam logic [15:0] CODE_INTERNAL = 16'h00CD;
  localparam logic [31:0] DET_SPARE     = 32'h0000_4000;
  localparam logic [31:0] DET_FAN       = 32'h0000_0080;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_WARN    = 8'h08;
  localparam logic [7:0] OFF_EVID    = 8'h0C;
  localparam logic [7:0] OFF_EVDET   = 8'h10;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h1C;

  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_TEST_BIT  = 1;
  localparam int WARN_FAN_BIT   = 0;
  localparam int WARN_SPARE_BIT = 1;
  localparam int IRQ_EVENT      = 0;
  localparam int IRQ_DIAG       = 1;
  localparam int IRQ_LATCH      = 2;
  localparam int IRQ_BLOCK      = 3;
  localparam int IRQ_W          = 4;
  localparam int STAT_ON_LSB    = 0;
  localparam int STAT_BAD_LSB   = 2;
  localparam int STAT_KIND_LSB  = 4;
  localparam int STAT_FSM_LSB   = 8;
  localparam int STAT_LATCH_BIT = 12;

  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_SELFTEST = 3'b000,
    ST_OPERATE  = 3'b001,
    ST_CYCTEST  = 3'b010,
    ST_BLOCKED  = 3'b011,
    ST_LATCHRST = 3'b100
  } cfs_state_t;

  typedef enum logic [1:0] {
    KIND_NONE   = 2'b00,
    KIND_SINGLE = 2'b01,
    KIND_PAIR   = 2'b10
  } cfs_kind_t;

endpackage

// file: hdl/cfs_tick.sv
// Millisecond enable divider.
// Assumes the single system clock; tick is high one cycle per period.
`timescale 1ns/1ns
module cfs_tick
  import cfs_pkg::*;
#(
  parameter int unsigned DIV = TICK_CYC
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Enable out
  output logic      tick
);

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_tick;

  always_comb begin
    next_cnt  = cnt + 32'h0000_0001;
    next_tick = 1'b0;
    if (cnt == DIV - 1) begin
      next_cnt  = 32'h0000_0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt  <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule

// file: hdl/cfs_tach.sv
// Speed judge for one fan from its tacho pulses.
// Assumes tach is synchronous; the first window after switch-on is spin-up.
`timescale 1ns/1ns
module cfs_tach
  import cfs_pkg::*;
#(
  parameter int unsigned WIN_TICKS = WIN_MS,
  parameter int unsigned MIN_CNT   = MIN_PULSES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Fan side
  input  wire logic fan_on,
  input  wire logic ms_tick,
  input  wire logic tach,
  // Verdict pulses
  output logic      judge_ok,
  output logic      judge_bad
);

  logic        tach_q, armed, next_armed, next_ok, next_bad;
  logic [7:0]  cnt, next_cnt;
  logic [15:0] win, next_win;

  always_comb begin
    next_cnt   = cnt;
    next_win   = win;
    next_armed = armed;
    next_ok    = 1'b0;
    next_bad   = 1'b0;
    if (!fan_on) begin
      next_cnt   = 8'h00;
      next_win   = 16'h0000;
      next_armed = 1'b0;
    end else begin
      if (tach && !tach_q && cnt != 8'hFF) next_cnt = cnt + 8'h01;
      if (ms_tick) begin
        if (win == 16'(WIN_TICKS - 1)) begin
          next_win   = 16'h0000;
          next_cnt   = 8'h00;
          next_armed = 1'b1;
          next_ok    = armed && cnt >= 8'(MIN_CNT);
          next_bad   = armed && cnt < 8'(MIN_CNT);
        end else begin
          next_win = win + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tach_q    <= 1'b0;
      cnt       <= 8'h00;
      win       <= 16'h0000;
      armed     <= 1'b0;
      judge_ok  <= 1'b0;
      judge_bad <= 1'b0;
    end else begin
      tach_q    <= tach;
      cnt       <= next_cnt;
      win       <= next_win;
      armed     <= next_armed;
      judge_ok  <= next_ok;
      judge_bad <= next_bad;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_judge_while_on: assert property (@(posedge clock) disable iff (rst)
    (judge_ok || judge_bad) |-> $past(fan_on))
    else $error("fan judged while switched off");

endmodule

// file: hdl/cfs_top.sv
// Cooling fan supervisor: fan control, fan tests, fault events, AHB-Lite registers.
// Assumes all inputs are synchronous to clock and rst is the power-on reset.
`timescale 1ns/1ns
module cfs_top
  import cfs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES    = TICK_CYC,
  parameter int unsigned MINUTE_TICKS   = MINUTE_MS,
  parameter int unsigned TEST_TICKS     = TEST_MS,
  parameter int unsigned INTERVAL_TICKS = INTERVAL_MS,
  parameter int unsigned BLINK_TICKS    = BLINK_HALF_MS,
  parameter int unsigned WIN_TICKS      = WIN_MS
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Fan unit
  input  wire logic [1:0]  fan_sense,
  input  wire logic [1:0]  fan_tach,
  output logic [1:0]       fan_on,
  output logic [1:0]       fan_full,
  // Cooling demand and run state
  input  wire logic        air_hot,
  input  wire logic        cpu_load_high,
  input  wire logic        run_mode,
  // Indicators and system
  output logic             load_enable,
  output logic             rdy_green,
  output logic             rdy_red,
  output logic             rdy_yellow,
  output logic             seg_eight,
  output logic             reset_state,
  output logic             peripheral_fault_event,
  output logic [15:0]      event_id_word,
  output logic [31:0]      event_detail_word,
  output logic             diag_entry,
  output logic             irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  cfs_state_t        state, next_state;
  cfs_kind_t         kind, next_kind;
  logic [31:0]       tmr, next_tmr, itv, next_itv, mins, next_mins, blk, next_blk;
  logic              blink, next_blink, next_latched, next_ev, next_diag;
  logic [1:0]        seen, next_seen, fan_bad, next_bad, prev_bad, next_prev;
  logic [1:0]        next_fan_on, judge_ok, judge_bad, good, fail_new;
  logic              fan_flag, next_fan_flag, spare_flag, next_spare_flag;
  logic              force_on, next_force;
  logic [15:0]       next_id;
  logic [31:0]       next_detail;
  logic [IRQ_W-1:0]  irq_st, next_irq_st, irq_en, next_irq_en, irq_set;
  logic              ms_tick, testing, demand, spare_case, cool_need;
  logic              wr_pend, next_wr_pend;
  logic [7:0]        addr_q, next_addr;
  logic [31:0]       next_hrdata, rd_word;
  logic              wr_ctrl, wr_warn, wr_irq_en, wr_irq_clr, ctrl_test;

  function automatic logic [1:0] fans_good(input logic [1:0] sense, input logic [1:0] bad);
    fans_good = sense & ~bad;
  endfunction

  // ----------------------------------------
  // Enables and speed judges
  // ----------------------------------------
  cfs_tick #(.DIV(TICK_CYCLES)) u_tick (
    .clock (clock),
    .rst   (rst),
    .tick  (ms_tick)
  );

  for (genvar i = 0; i < 2; i++) begin : g_tach
    cfs_tach #(.WIN_TICKS(WIN_TICKS), .MIN_CNT(MIN_PULSES)) u_tach (
      .clock     (clock),
      .rst       (rst),
      .fan_on    (fan_on[i]),
      .ms_tick   (ms_tick),
      .tach      (fan_tach[i]),
      .judge_ok  (judge_ok[i]),
      .judge_bad (judge_bad[i])
    );
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  // Zero wait states; read data is caught in the address phase.
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign wr_ctrl    = wr_pend && addr_q == OFF_CTRL;
  assign wr_warn    = wr_pend && addr_q == OFF_WARN;
  assign wr_irq_en  = wr_pend && addr_q == OFF_IRQ_EN;
  assign wr_irq_clr = wr_pend && addr_q == OFF_IRQ_CLR;
  assign ctrl_test  = wr_ctrl && hwdata[CTRL_TEST_BIT];

  always_comb begin
    rd_word = 32'h0000_0000;
    if (haddr[7:0] == OFF_CTRL) begin
      rd_word[CTRL_FORCE_BIT] = force_on;
    end else if (haddr[7:0] == OFF_STATUS) begin
      rd_word[STAT_ON_LSB +: 2]   = fan_on;
      rd_word[STAT_BAD_LSB +: 2]  = fan_bad;
      rd_word[STAT_KIND_LSB +: 2] = kind;
      rd_word[STAT_FSM_LSB +: 3]  = state;
      rd_word[STAT_LATCH_BIT]     = reset_state;
    end else if (haddr[7:0] == OFF_WARN) begin
      rd_word[WARN_FAN_BIT]   = fan_flag;
      rd_word[WARN_SPARE_BIT] = spare_flag;
    end else if (haddr[7:0] == OFF_EVID) begin
      rd_word[15:0] = event_id_word;
    end else if (haddr[7:0] == OFF_EVDET) begin
      rd_word = event_detail_word;
    end else if (haddr[7:0] == OFF_IRQ_ST) begin
      rd_word[IRQ_W-1:0] = irq_st;
    end else if (haddr[7:0] == OFF_IRQ_EN) begin
      rd_word[IRQ_W-1:0] = irq_en;
    end
  end

  always_comb begin
    next_wr_pend = 1'b0;
    next_addr    = addr_q;
    next_hrdata  = hrdata;
    if (hsel && htrans[1] && hready) begin
      next_addr    = haddr[7:0];
      next_wr_pend = hwrite;
      next_hrdata  = hwrite ? 32'h0000_0000 : rd_word;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      addr_q  <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_pend <= next_wr_pend;
      addr_q  <= next_addr;
      hrdata  <= next_hrdata;
    end
  end

  // ----------------------------------------
  // Supervisor core
  // ----------------------------------------
  assign testing    = state == ST_SELFTEST || state == ST_CYCTEST;
  assign demand     = air_hot || cpu_load_high;
  assign good       = fans_good(fan_sense, fan_bad);
  assign fail_new   = fan_bad & ~prev_bad & fan_sense;
  assign spare_case = kind == KIND_PAIR && good != 2'b00;
  // Dead pair needs the fail timer even when cool, since nothing can cool
  assign cool_need  = demand || (kind == KIND_PAIR && fan_bad == 2'b11);
  assign irq_set    = {state != ST_BLOCKED && next_state == ST_BLOCKED,
                       next_latched && !reset_state, next_diag, next_ev};

  always_comb begin
    next_state      = state;
    next_kind       = KIND_NONE;
    next_tmr        = tmr;
    next_itv        = itv;
    next_mins       = 32'h0000_0000;
    next_blk        = blk;
    next_blink      = blink;
    next_seen       = seen;
    next_bad        = fan_bad;
    next_prev       = fan_bad;
    next_latched    = reset_state;
    next_ev         = 1'b0;
    next_diag       = 1'b0;
    next_id         = event_id_word;
    next_detail     = event_detail_word;
    next_force      = wr_ctrl ? hwdata[CTRL_FORCE_BIT] : force_on;
    next_irq_en     = wr_irq_en ? hwdata[IRQ_W-1:0] : irq_en;
    // Clear by writing zero; a set in the same cycle wins below
    next_fan_flag   = fan_flag && !(wr_warn && !hwdata[WARN_FAN_BIT]);
    next_spare_flag = spare_flag && !(wr_warn && !hwdata[WARN_SPARE_BIT]);
    if (fan_sense == 2'b11) next_kind = KIND_PAIR;
    else if (fan_sense != 2'b00) next_kind = KIND_SINGLE;
    case (state)
      ST_SELFTEST: begin
        next_seen = seen | judge_ok;
        if (ms_tick) next_tmr = tmr + 32'h0000_0001;
        if (ms_tick && tmr == TEST_TICKS - 1) begin
          next_tmr  = 32'h0000_0000;
          next_bad  = fan_sense & ~next_seen;
          next_prev = next_bad;
          if (next_bad != 2'b00 || fan_sense != 2'b11) next_diag = 1'b1;
          if (fan_sense == 2'b11 && next_bad != 2'b11) begin
            next_spare_flag = next_bad != 2'b00;
          end else begin
            next_fan_flag = 1'b1;
          end
          if ((fan_sense & next_seen) != 2'b00) next_state = ST_OPERATE;
          else next_state = ST_BLOCKED;
        end
      end
      ST_OPERATE: begin
        if (ms_tick) next_itv = itv + 32'h0000_0001;
        if ((ms_tick && itv == INTERVAL_TICKS - 1) || ctrl_test) begin
          next_itv   = 32'h0000_0000;
          next_state = ST_CYCTEST;
        end
      end
      ST_CYCTEST: begin
        if (ms_tick) next_tmr = tmr + 32'h0000_0001;
        if (ms_tick && tmr == TEST_TICKS - 1) begin
          next_tmr   = 32'h0000_0000;
          next_state = ST_OPERATE;
        end
      end
      ST_BLOCKED: begin
        if (ms_tick) next_blk = blk + 32'h0000_0001;
        if (ms_tick && blk == BLINK_TICKS - 1) begin
          next_blk   = 32'h0000_0000;
          next_blink = !blink;
        end
      end
      default: ;
    endcase
    if (state == ST_OPERATE || state == ST_CYCTEST) begin
      next_bad = (fan_bad | judge_bad) & ~judge_ok;
    end
    if (fail_new != 2'b00) begin
      next_diag = 1'b1;
      if (spare_case) next_spare_flag = 1'b1;
      else next_fan_flag = 1'b1;
      if (run_mode) begin
        next_ev     = 1'b1;
        next_id     = CODE_INTERNAL;
        next_detail = spare_case ? DET_SPARE : DET_FAN;
      end
    end
    if (cool_need && good == 2'b00 && !reset_state) begin
      next_mins = mins;
      if (ms_tick) next_mins = mins + 32'h0000_0001;
      if (ms_tick && mins == MINUTE_TICKS - 1) next_latched = 1'b1;
    end
    if (next_latched) next_state = ST_LATCHRST;
    next_irq_st = (irq_st & ~(wr_irq_clr ? hwdata[IRQ_W-1:0] : 4'h0)) | irq_set;
    // Faulty fans stay on so the survivor carries load and recovery shows
    next_fan_on = {2{testing || demand || force_on || next_bad != 2'b00}};
    if (next_state == ST_SELFTEST || next_state == ST_CYCTEST) next_fan_on = 2'b11;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state                  <= ST_SELFTEST;
      kind                   <= KIND_NONE;
      tmr                    <= 32'h0000_0000;
      itv                    <= 32'h0000_0000;
      mins                   <= 32'h0000_0000;
      blk                    <= 32'h0000_0000;
      blink                  <= 1'b0;
      seen                   <= 2'b00;
      fan_bad                <= 2'b00;
      prev_bad               <= 2'b00;
      fan_on                 <= 2'b00;
      reset_state            <= 1'b0;
      fan_flag               <= 1'b0;
      spare_flag             <= 1'b0;
      force_on               <= 1'b0;
      peripheral_fault_event <= 1'b0;
      diag_entry             <= 1'b0;
      event_id_word          <= 16'h0000;
      event_detail_word      <= 32'h0000_0000;
      irq_st                 <= 4'h0;
      irq_en                 <= IRQ_EN_RST;
    end else begin
      state                  <= next_state;
      kind                   <= next_kind;
      tmr                    <= next_tmr;
      itv                    <= next_itv;
      mins                   <= next_mins;
      blk                    <= next_blk;
      blink                  <= next_blink;
      seen                   <= next_seen;
      fan_bad                <= next_bad;
      prev_bad               <= next_prev;
      fan_on                 <= next_fan_on;
      reset_state            <= next_latched;
      fan_flag               <= next_fan_flag;
      spare_flag             <= next_spare_flag;
      force_on               <= next_force;
      peripheral_fault_event <= next_ev;
      diag_entry             <= next_diag;
      event_id_word          <= next_id;
      event_detail_word      <= next_detail;
      irq_st                 <= next_irq_st;
      irq_en                 <= next_irq_en;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign fan_full    = fan_on & good & {fan_bad[0], fan_bad[1]};
  assign load_enable = state == ST_OPERATE || state == ST_CYCTEST;
  assign rdy_green   = load_enable;
  assign rdy_red     = (state == ST_BLOCKED && blink) || reset_state;
  assign rdy_yellow  = state == ST_BLOCKED && !blink;
  assign seg_eight   = reset_state;
  assign irq         = (irq_st & irq_en) != 4'h0;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_latch_holds: assert property (reset_state |=> reset_state && state == ST_LATCHRST)
    else $error("latched reset state released");
  a_blocked_no_load: assert property (state == ST_BLOCKED |-> !load_enable)
    else $error("load enabled while blocked");
  a_blink_alt: assert property (state == ST_BLOCKED |-> rdy_red != rdy_yellow)
    else $error("ready indicator not alternating");
  a_seg_shows: assert property ($rose(reset_state) |-> seg_eight && !load_enable)
    else $error("reset state without eight shown");
  a_spare_event: assert property (
    fail_new != 2'b00 && run_mode && spare_case |=> peripheral_fault_event
      && event_detail_word == DET_SPARE && event_id_word == CODE_INTERNAL && spare_flag)
    else $error("spare loss event wrong");
  a_fan_event: assert property (
    fail_new != 2'b00 && run_mode && !spare_case |=> peripheral_fault_event
      && event_detail_word == DET_FAN && fan_flag)
    else $error("fan fault event wrong");
  a_stop_quiet: assert property (
    fail_new != 2'b00 && !run_mode |=> !peripheral_fault_event && diag_entry)
    else $error("event raised for failure in stop");
  a_full_load: assert property (
    kind == KIND_PAIR && ^fan_bad && fan_sense == 2'b11 |-> fan_full == ~fan_bad)
    else $error("survivor not at full load");
  a_test_fans: assert property (testing && $past(testing) && !$past(rst) |-> fan_on == 2'b11)
    else $error("fans off during test");
  a_flag_holds: assert property (fan_flag && !wr_warn |=> fan_flag)
    else $error("fan flag dropped without write");

  c_spare_event: cover property (peripheral_fault_event && event_detail_word == DET_SPARE);
  c_latched: cover property ($rose(reset_state));
  c_blocked: cover property (state == ST_BLOCKED && $rose(blink));
  c_cyc_test: cover property (state == ST_OPERATE ##1 state == ST_CYCTEST);

endmodule

// file: test/cfs_fan_model.sv
// Behavioural fan pair with tacho feedback, fault injection per fan.
// Assumes the supervisor clock; a healthy fan gives one pulse per 2 cycles.
`timescale 1ns/1ns
module cfs_fan_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Supervisor drive and faults
  input  wire logic [1:0] fan_on,
  input  wire logic [1:0] slow,
  input  wire logic [1:0] dead,
  // Speed feedback
  output logic [1:0]      fan_tach
);
  logic [2:0] rot [2];

  // Rotor stands still when off or seized, so no stale pulses
  always_ff @(posedge clock or posedge rst) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        rot[i] <= 3'h0;
      end else if (fan_on[i] && !dead[i]) begin
        rot[i] <= rot[i] + 3'h1;
      end
    end
  end

  // Slow fan: a quarter of the speed, under the limit
  assign fan_tach[0] = slow[0] ? rot[0][2] : rot[0][0];
  assign fan_tach[1] = slow[1] ? rot[1][2] : rot[1][0];
endmodule

// file: test/tb_top.sv
// Self-checking bench for the fan supervisor with an AHB-Lite master.
// Assumes shortened timing parameters; one tick is 10 clocks.
`timescale 1ns/1ns
module tb_top
  import cfs_pkg::*;
;
  logic        clock, rst, hsel, hwrite, hreadyout, hresp, air_hot, cpu_load_high, run_mode;
  logic [31:0] haddr, hwdata, hrdata, event_detail_word, q;
  logic [1:0]  htrans, fan_sense, fan_tach, fan_on, fan_full, slow, dead;
  logic [2:0]  hsize;
  logic [15:0] event_id_word;
  logic        load_enable, rdy_green, rdy_red, rdy_yellow, seg_eight, reset_state;
  logic        peripheral_fault_event, diag_entry, irq, prev;
  logic [16:0] seed;
  int          error_cnt, num_checks, t;

  cfs_top #(.TICK_CYCLES(10), .MINUTE_TICKS(20), .TEST_TICKS(8), .INTERVAL_TICKS(30),
    .BLINK_TICKS(3), .WIN_TICKS(3)) u_dut (.clock(clock), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fan_sense(fan_sense), .fan_tach(fan_tach), .fan_on(fan_on), .fan_full(fan_full),
    .air_hot(air_hot), .cpu_load_high(cpu_load_high), .run_mode(run_mode),
    .load_enable(load_enable), .rdy_green(rdy_green), .rdy_red(rdy_red),
    .rdy_yellow(rdy_yellow), .seg_eight(seg_eight), .reset_state(reset_state),
    .peripheral_fault_event(peripheral_fault_event), .event_id_word(event_id_word),
    .event_detail_word(event_detail_word), .diag_entry(diag_entry), .irq(irq));
  cfs_fan_model u_fan (.clock(clock), .rst(rst), .fan_on(fan_on), .slow(slow),
    .dead(dead), .fan_tach(fan_tach));

  always #10 clock = ~clock;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  function automatic logic probe(input int k);
    case (k)
      0: return load_enable;
      1: return peripheral_fault_event;
      2: return reset_state;
      3: return fan_on[1];
      4: return rdy_red;
      default: return diag_entry;
    endcase
  endfunction

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait on settled values, sampled mid-cycle
  task automatic wait_on(input int k, input logic v, input int lim);
    for (int n = 0; n < lim && probe(k) !== v; n++) @(negedge clock);
    chk(probe(k), v);
    if (probe(k) !== v) finish_test();
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    hsize <= 3'b010;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hsize <= 3'b000;
    hwdata <= d;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 100);
    q = hrdata;
    if (n >= 100) begin
      error_cnt++;
      finish_test();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {clock, hsel, haddr, htrans, hwrite, hwdata, air_hot, cpu_load_high, slow, dead} = '0;
    {rst, run_mode, fan_sense, hsize} = {1'b1, 1'b1, 2'b11, 3'b010};
    seed = 17'h1_35a6;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    wait_on(0, 1'b1, 300);
    bus(1'b0, OFF_STATUS, 32'h0000_0000);
    chk({q[10:8], q[5:2]}, {ST_OPERATE, KIND_PAIR, 2'b00});
    chk({rdy_green, hresp}, 2'b10);
    wait_on(3, 1'b0, 50);
    wait_on(3, 1'b1, 400);
    repeat (20) begin
      @(posedge clock);
      seed = lfsr_next(seed);
      cpu_load_high <= seed[0];
      hwdata <= {15'h0000, seed};
    end
    @(posedge clock);
    cpu_load_high <= 1'b0;
    air_hot <= 1'b1;
    repeat (3) @(negedge clock);
    chk(fan_on, 2'b11);
    bus(1'b1, OFF_IRQ_EN, 32'h0000_0001);
    slow[1] <= 1'b1;
    wait_on(1, 1'b1, 300);
    chk(event_id_word, CODE_INTERNAL);
    chk(event_detail_word, DET_SPARE);
    chk(fan_full[0], 1'b1);
    chk(irq, 1'b1);
    bus(1'b0, OFF_WARN, 32'h0000_0000);
    chk(q[1:0], 2'b10);
    bus(1'b1, OFF_WARN, 32'h0000_0000);
    bus(1'b0, OFF_WARN, 32'h0000_0000);
    chk(q[1:0], 2'b00);
    bus(1'b1, OFF_IRQ_CLR, 32'h0000_0001);
    @(negedge clock);
    chk(irq, 1'b0);
    dead[0] <= 1'b1;
    wait_on(1, 1'b1, 300);
    chk(event_detail_word, DET_FAN);
    bus(1'b0, OFF_WARN, 32'h0000_0000);
    chk(q[1:0], 2'b01);
    wait_on(2, 1'b1, 400);
    chk(seg_eight, 1'b1);
    @(posedge clock);
    air_hot <= 1'b0;
    run_mode <= 1'b0;
    bus(1'b1, OFF_CTRL, 32'h0000_0000);
    repeat (50) @(negedge clock);
    chk({reset_state, load_enable}, 2'b10);
    // Spare lost in stop: flag and diagnostic entry, no event
    @(posedge clock);
    {slow, dead} <= '0;
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    wait_on(0, 1'b1, 300);
    @(posedge clock);
    {dead[1], cpu_load_high} <= 2'b11;
    wait_on(5, 1'b1, 300);
    chk({peripheral_fault_event, event_id_word}, 32'h0000_0000);
    bus(1'b0, OFF_WARN, 32'h0000_0000);
    chk(q[1:0], 2'b10);
    // No fan fitted: blocked and flashing, not latched without demand
    @(posedge clock);
    {fan_sense, slow, dead, cpu_load_high} <= '0;
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    wait_on(4, 1'b1, 300);
    t = 0;
    prev = rdy_red;
    repeat (90) begin
      @(negedge clock);
      t += (rdy_red !== prev);
      prev = rdy_red;
    end
    chk(t >= 2, 1'b1);
    chk(load_enable, 1'b0);
    chk({rdy_green, rdy_red ^ rdy_yellow, hresp}, 3'b010);
    bus(1'b0, OFF_STATUS, 32'h0000_0000);
    chk({q[10:8], q[5:4]}, {ST_BLOCKED, KIND_NONE});
    finish_test();
  end

  initial begin
    #200_000;
    error_cnt++;
    finish_test();
  end
endmodule
